/* File: bench/ivg_src_model.sv */
`timescale 1ns/1ps
// ----
// Peripheral request sources beside the pending register.
// ----
module ivg_src_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] lvl_value,
  input wire logic [9:0] cond_fire,
  input wire logic byte_fire,
  output logic video_irq,
  output logic [7:0] prog_io_irq_field,
  output logic channel0_transfer_irq,
  output logic channel1_transfer_irq,
  output logic serial_rx_status_irq,
  output logic serial_rx_data_irq,
  output logic serial_tx_empty_irq,
  output logic parport_byte_event,
  output logic [9:0] parport_cond_event,
  output logic [7:0] parport_rx_byte
);
  // Levels follow the pending word layout.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {video_irq, prog_io_irq_field, channel0_transfer_irq, channel1_transfer_irq} <= '0;
      {serial_rx_status_irq, serial_rx_data_irq, serial_tx_empty_irq} <= '0;
    end else begin
      {video_irq, prog_io_irq_field} <= {lvl_value[27], lvl_value[23:16]};
      {channel0_transfer_irq, channel1_transfer_irq} <= lvl_value[14:13];
      {serial_rx_status_irq, serial_rx_data_irq, serial_tx_empty_irq} <= lvl_value[7:5];
    end
  end
  // Events last one cycle; the byte bus moves every cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {parport_byte_event, parport_cond_event} <= '0;
      parport_rx_byte <= 8'h5A;
    end else begin
      {parport_byte_event, parport_cond_event} <= {byte_fire, cond_fire};
      parport_rx_byte <= parport_rx_byte + 8'h01;
    end
  end
endmodule

/* File: bench/ivg_top_asserts.sv */
`timescale 1ns/1ps
// ----
// Port checks for the status and vector block.
// ----
module ivg_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic video_irq,
  input wire logic [7:0] prog_io_irq_field,
  input wire logic channel0_transfer_irq,
  input wire logic channel1_transfer_irq,
  input wire logic serial_rx_status_irq,
  input wire logic serial_rx_data_irq,
  input wire logic serial_tx_empty_irq,
  input wire logic internal_irq,
  input wire logic trap_take,
  input wire ivg_pkg::ivg_cause_t trap_cause,
  input wire logic [1:0] trap_miss_kind,
  input wire logic [7:0] trap_instr_vector,
  input wire logic align_check_enable,
  input wire logic periph_trap,
  input wire logic vector_valid,
  input wire logic [7:0] vector_num,
  input wire logic [31:0] vector_addr
);
  // Every check samples on the rising clock and rests in reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic src_any;
  logic take_c;
  // A level request, and a take that the cause alone decides.
  assign src_any = video_irq | (|prog_io_irq_field) | channel0_transfer_irq
    | channel1_transfer_irq | serial_rx_status_irq | serial_rx_data_irq | serial_tx_empty_irq;
  assign take_c = trap_take & ~periph_trap;
  chk_src_line: assert property (src_any |=> internal_irq)
    else $error("internal line missing");
  chk_setup_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_bad_trap: assert property (pready && pslverr |=> periph_trap)
    else $error("no trap after refused access");
  chk_bad_vec: assert property (periph_trap |=> vector_valid && vector_num == 8'h06)
    else $error("wrong trap vector");
  chk_vec_slot: assert property (vector_valid |-> vector_addr[9:2] == vector_num)
    else $error("vector slot wrong");
  chk_vec_cause: assert property (vector_valid |-> $past(trap_take) || $past(periph_trap))
    else $error("vector without take");
  chk_timer_vec: assert property (take_c && trap_cause == ivg_pkg::CAUSE_TIMER
    |=> vector_valid && vector_num == 8'h0E)
    else $error("timer vector wrong");
  chk_miss_order: assert property (take_c && trap_cause == ivg_pkg::CAUSE_MISS
    |=> vector_num == 8'h08 + $past(trap_miss_kind))
    else $error("miss vector wrong");
  chk_given_vec: assert property (take_c && trap_cause == ivg_pkg::CAUSE_INSTR_VEC
    |=> vector_num == $past(trap_instr_vector))
    else $error("given vector wrong");
  chk_align_off: assert property (take_c && trap_cause == ivg_pkg::CAUSE_UNALIGNED
    && !align_check_enable |=> !vector_valid)
    else $error("unaligned vector while unchecked");
  cov_refused: cover property (pready && pslverr);
  cov_vec6: cover property (vector_valid && vector_num == 8'h06);
  cov_line: cover property (src_any && internal_irq);
endmodule

/* File: bench/tb_irq_status_and_vector_gen.sv */
`timescale 1ns/1ps
`include "ivg_consts.svh"
// ----
// Self-checking bench for the status and vector block.
// ----
module tb_irq_status_and_vector_gen;
  localparam logic [31:0] SRC_MASK = 32'h08FF60E0;
  localparam logic [3:0] CD [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8, 4'h9,
    4'hA, 4'hB, 4'h4};
  localparam logic [7:0] EV [11] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h0E, 8'h0F, 8'h10, 8'h12,
    8'h13, 8'h16, 8'h06};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, byte_fire, err;
  logic [31:0] paddr, pwdata, prdata, lvl_value, vector_addr, base, rv;
  logic [9:0] cond_fire, parport_cond_event;
  logic [7:0] prog_io_irq_field, parport_rx_byte, parport_tx_byte, b;
  logic [7:0] trap_emu_opcode, trap_instr_vector, vector_num;
  logic video_irq, channel0_transfer_irq, channel1_transfer_irq, serial_rx_status_irq;
  logic serial_rx_data_irq, serial_tx_empty_irq, parport_byte_event, parport_compat_mode;
  logic parport_tx_load, parport_rx_taken, parport_dma_req, internal_irq, trap_take;
  logic align_check_enable, periph_trap, vector_valid;
  logic [1:0] trap_miss_kind;
  logic [4:0] trap_emu_instr;
  ivg_pkg::ivg_cause_t trap_cause;
  int miscompares, comparisons, cycles, i;
  ivg_top ivg_top_i (.*);
  ivg_src_model ivg_src_model_i (.*);
  // Clock and hang guard.
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  function automatic logic [31:0] exp_addr(input logic [31:0] bs, input logic [7:0] n);
    return {bs[31:10], n, bs[1:0]};
  endfunction
  function automatic logic [7:0] emu_vec(input logic [7:0] op);
    return (op <= 8'hDD) ? op - 8'hD8 + 8'h18 : op - 8'hE7 + 8'h27;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, err);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rv, err);
    chk(rv, e);
  endtask
  task automatic fire(input logic [9:0] c, input logic bt);
    {cond_fire, byte_fire} <= {c, bt};
    @(posedge pclk);
    {cond_fire, byte_fire} <= '0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic trap(input ivg_pkg::ivg_cause_t c, input logic [7:0] x, input logic v,
      input logic [7:0] e);
    trap_cause <= c;
    {trap_miss_kind, trap_emu_opcode} <= {x[1:0], x};
    {trap_emu_instr, trap_instr_vector, trap_take} <= {x[4:0], x, 1'b1};
    @(posedge pclk);
    trap_take <= 1'b0;
    @(posedge pclk);
    chk({31'h0, vector_valid}, {31'h0, v});
    if (v) begin
      chk({24'h0, vector_num}, {24'h0, e});
      chk(vector_addr, exp_addr(base, e));
    end
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'hA5C5));
    {pclk, presetn, psel, penable, pwrite, byte_fire, parport_compat_mode} = '0;
    {trap_take, align_check_enable, paddr, pwdata, lvl_value, cond_fire} = '0;
    {trap_miss_kind, trap_emu_opcode, trap_emu_instr, trap_instr_vector} = '0;
    trap_cause = ivg_pkg::CAUSE_ILLEGAL;
    base = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`IVG_ADDR_PENDING, 32'h0);
    rd(`IVG_ADDR_COND_MASK, 32'h0);
    rd(`IVG_ADDR_VEC_BASE, 32'h0);
    $display("test reset done");
    for (i = 0; i < 20; i++) begin
      lvl_value <= (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h00800000 : $urandom;
      repeat (3) @(posedge pclk);
      rd(`IVG_ADDR_PENDING, lvl_value & SRC_MASK);
      chk({31'h0, internal_irq}, {31'h0, |(lvl_value & SRC_MASK)});
    end
    lvl_value <= 32'h0;
    $display("test sources done");
    wr(`IVG_ADDR_CONTROL, 32'h0);
    fire(10'h0, 1'b1);
    rd(`IVG_ADDR_PENDING, 32'h1000);
    b = $urandom;
    wr(`IVG_ADDR_DATA, {24'h0, b});
    chk({23'h0, parport_tx_load, parport_tx_byte}, {23'h0, 1'b1, b});
    rd(`IVG_ADDR_PENDING, 32'h0);
    fire(10'h0, 1'b1);
    wr(`IVG_ADDR_DATA_REQ, 32'h1);
    rd(`IVG_ADDR_PENDING, 32'h0);
    wr(`IVG_ADDR_CONTROL, 32'h2);
    fire(10'h0, 1'b1);
    apb(1'b0, `IVG_ADDR_DATA, 32'h0, rv, err);
    chk({31'h0, parport_rx_taken}, 32'h1);
    rd(`IVG_ADDR_PENDING, 32'h0);
    wr(`IVG_ADDR_CONTROL, 32'h1);
    fire(10'h0, 1'b1);
    rd(`IVG_ADDR_PENDING, 32'h0);
    chk({31'h0, parport_dma_req}, 32'h1);
    wr(`IVG_ADDR_DATA_REQ, 32'h1);
    @(posedge pclk);
    chk({31'h0, parport_dma_req}, 32'h0);
    $display("test transfer done");
    wr(`IVG_ADDR_COND_MASK, 32'h3FF);
    rd(`IVG_ADDR_COND_MASK, 32'h3FF);
    fire(10'h008, 1'b0);
    rd(`IVG_ADDR_PENDING, 32'h800);
    rd(`IVG_ADDR_COND_FLAGS, 32'h8);
    wr(`IVG_ADDR_COND_FLAGS, 32'h8);
    rd(`IVG_ADDR_COND_STATUS, 32'h0);
    rd(`IVG_ADDR_PENDING, 32'h800);
    wr(`IVG_ADDR_PENDING, 32'h800);
    rd(`IVG_ADDR_PENDING, 32'h0);
    wr(`IVG_ADDR_COND_MASK, 32'h0);
    fire(10'h020, 1'b0);
    rd(`IVG_ADDR_PENDING, 32'h0);
    wr(`IVG_ADDR_COND_STATUS, 32'h20);
    rd(`IVG_ADDR_COND_STATUS, 32'h0);
    fire(10'h002, 1'b0);
    wr(`IVG_ADDR_COND_STATUS, 32'h2);
    rd(`IVG_ADDR_COND_STATUS, 32'h2);
    parport_compat_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(`IVG_ADDR_COND_STATUS, 32'h0);
    parport_compat_mode <= 1'b0;
    $display("test conditions done");
    base = $urandom;
    wr(`IVG_ADDR_VEC_BASE, base);
    rd(`IVG_ADDR_VEC_BASE, base);
    align_check_enable <= 1'b1;
    for (i = 0; i < 11; i++) begin
      trap(ivg_pkg::ivg_cause_t'(CD[i]), 8'h00, 1'b1, EV[i]);
    end
    for (i = 0; i < 4; i++) begin
      trap(ivg_pkg::CAUSE_MISS, 8'(i), 1'b1, 8'h08 + 8'(i));
    end
    for (i = 0; i < 9; i++) begin
      b = (i < 6) ? 8'hD8 + 8'(i) : 8'hE7 + 8'(i - 6);
      trap(ivg_pkg::CAUSE_EMU_OPCODE, b, 1'b1, emu_vec(b));
    end
    trap(ivg_pkg::CAUSE_EMU_OPCODE, 8'hDE, 1'b0, 8'h00);
    for (i = 0; i < 28; i++) begin
      trap(ivg_pkg::CAUSE_EMU_INSTR, 8'(i), 1'b1, 8'h1E + 8'(i));
    end
    for (i = 0; i < 8; i++) begin
      b = (i == 0) ? 8'h40 : (i == 1) ? 8'hFF : 8'($urandom_range(255, 64));
      trap(ivg_pkg::CAUSE_INSTR_VEC, b, 1'b1, b);
    end
    align_check_enable <= 1'b0;
    trap(ivg_pkg::CAUSE_UNALIGNED, 8'h00, 1'b0, 8'h00);
    $display("test vectors done");
    apb(1'b0, 32'h80000060, 32'h0, rv, err);
    chk({err, rv[30:0]}, 32'h80000000);
    chk({31'h0, periph_trap}, 32'h1);
    @(posedge pclk);
    chk({23'h0, vector_valid, vector_num}, 32'h00000106);
    $display("test unmapped done");
    results();
  end
endmodule
bind ivg_top ivg_top_chk ivg_top_chk_i (.*);

/* File: design/ivg_cond_latch.sv */
`timescale 1ns/1ps
`include "ivg_consts.svh"
module ivg_cond_latch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [9:0] cond_event,
  input wire logic [9:0] cond_mask,
  input wire logic [9:0] clear_ones,
  input wire logic compat_mode,
  output logic [9:0] cond_status,
  output logic [9:0] cond_flags,
  output logic cond_any
);
  logic compat_d_reg;
  // -----------------------------------------------------------------
  // Condition latches
  // -----------------------------------------------------------------
  // Remember the compatibility mode level to see a return into it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compat_d_reg <= 1'b1;
    end else begin
      compat_d_reg <= compat_mode;
    end
  end
  genvar i;
  generate
    for (i = 0; i < `IVG_COND_NUM; i++) begin : g_cond
      logic clr;
      logic st_reg;
      if (i == `IVG_COND_DEVINIT) begin : g_init
        assign clr = compat_mode & ~compat_d_reg;
      end else begin : g_norm
        assign clr = clear_ones[i];
      end
      // A new event wins over a clear in the same cycle.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_reg <= 1'b0;
        end else if (cond_event[i]) begin
          st_reg <= 1'b1;
        end else if (clr) begin
          st_reg <= 1'b0;
        end
      end
      assign cond_status[i] = st_reg;
      assign cond_flags[i] = st_reg & cond_mask[i];
    end
  endgenerate
  // Any masked flag requests the combined condition interrupt.
  assign cond_any = |cond_flags;
endmodule

/* File: design/ivg_consts.svh */
`ifndef IVG_CONSTS_SVH
`define IVG_CONSTS_SVH
// Register byte addresses.
`define IVG_ADDR_PENDING 32'h80000028
`define IVG_ADDR_CONTROL 32'h80000040
`define IVG_ADDR_COND_STATUS 32'h80000044
`define IVG_ADDR_COND_MASK 32'h80000048
`define IVG_ADDR_COND_FLAGS 32'h8000004C
`define IVG_ADDR_DATA_REQ 32'h80000050
`define IVG_ADDR_DATA 32'h80000054
`define IVG_ADDR_VEC_BASE 32'h80000058
// Pending register field positions.
`define IVG_BIT_VIDEO 27
`define IVG_BIT_PIO_HI 23
`define IVG_BIT_PIO_LO 16
`define IVG_BIT_CH0 14
`define IVG_BIT_CH1 13
`define IVG_BIT_PDATA 12
`define IVG_BIT_PCOND 11
`define IVG_BIT_RXS 7
`define IVG_BIT_RXD 6
`define IVG_BIT_TXE 5
// Control register fields and condition layout.
`define IVG_CTL_DMA 0
`define IVG_CTL_DIR_RX 1
`define IVG_COND_NUM 10
`define IVG_COND_DEVINIT 1
// Reset values.
`define IVG_RST_ZERO 32'h00000000
`define IVG_RST_MASK 10'h000
// Fixed vector numbers.
`define IVG_VEC_ILLEGAL 8'h00
`define IVG_VEC_UNALIGNED 8'h01
`define IVG_VEC_RANGE 8'h02
`define IVG_VEC_PROTECT 8'h05
`define IVG_VEC_PERIPH 8'h06
`define IVG_VEC_MISS_BASE 8'h08
`define IVG_VEC_TIMER 8'h0E
`define IVG_VEC_TRACE 8'h0F
`define IVG_VEC_EXT0 8'h10
`define IVG_VEC_EXT2 8'h12
`define IVG_VEC_INTERNAL 8'h13
`define IVG_VEC_FPEXC 8'h16
`define IVG_VEC_EMU_D8 8'h18
`define IVG_VEC_EMU_E7 8'h27
`define IVG_VEC_EMU_INSTR 8'h1E
`define IVG_OP_D8 8'hD8
`define IVG_OP_DD 8'hDD
`define IVG_OP_E7 8'hE7
`define IVG_OP_E9 8'hE9
`endif

/* File: design/ivg_pkg.sv */
package ivg_pkg;
  // Cause of an interrupt or trap being taken.
  typedef enum logic [3:0] {
    CAUSE_ILLEGAL = 4'h0,
    CAUSE_UNALIGNED = 4'h1,
    CAUSE_RANGE = 4'h2,
    CAUSE_PROTECT = 4'h3,
    CAUSE_PERIPH = 4'h4,
    CAUSE_MISS = 4'h5,
    CAUSE_TIMER = 4'h6,
    CAUSE_TRACE = 4'h7,
    CAUSE_EXT0 = 4'h8,
    CAUSE_EXT2 = 4'h9,
    CAUSE_INTERNAL = 4'hA,
    CAUSE_FPEXC = 4'hB,
    CAUSE_EMU_OPCODE = 4'hC,
    CAUSE_EMU_INSTR = 4'hD,
    CAUSE_INSTR_VEC = 4'hE
  } ivg_cause_t;
endpackage

/* File: design/ivg_top.sv */
`timescale 1ns/1ps
`include "ivg_consts.svh"


module ivg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic video_irq,
  input wire logic [7:0] prog_io_irq_field,
  input wire logic channel0_transfer_irq,
  input wire logic channel1_transfer_irq,
  input wire logic serial_rx_status_irq,
  input wire logic serial_rx_data_irq,
  input wire logic serial_tx_empty_irq,
  input wire logic parport_byte_event,
  input wire logic [7:0] parport_rx_byte,
  input wire logic [9:0] parport_cond_event,
  input wire logic parport_compat_mode,
  output logic [7:0] parport_tx_byte,
  output logic parport_tx_load,
  output logic parport_rx_taken,
  output logic parport_dma_req,
  output logic internal_irq,
  input wire logic trap_take,
  input wire ivg_pkg::ivg_cause_t trap_cause,
  input wire logic [1:0] trap_miss_kind,
  input wire logic [7:0] trap_emu_opcode,
  input wire logic [4:0] trap_emu_instr,
  input wire logic [7:0] trap_instr_vector,
  input wire logic align_check_enable,
  output logic periph_trap,
  output logic vector_valid,
  output logic [7:0] vector_num,
  output logic [31:0] vector_addr
);
  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] pending_reg;
  logic cond_irq_reg;
  logic data_req_reg;
  logic [1:0] control_reg;
  logic [9:0] mask_reg;
  logic [31:0] vec_base_reg;

  logic [7:0] tx_byte_reg;
  logic tx_load_reg;
  logic rx_taken_reg;
  logic dma_req_reg;
  logic internal_irq_reg;
  logic periph_trap_reg;

  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] rdata_next;

  logic [9:0] cond_status;
  logic [9:0] cond_flags;
  logic cond_any;
  logic [9:0] cond_clear;
  logic data_access;
  logic data_req_clear;

  logic [31:0] pending_next;
  logic take_next;
  ivg_pkg::ivg_cause_t cause_next;

  logic vec_valid_reg;
  logic [7:0] vec_num_reg;
  logic [31:0] vec_addr_reg;

  // -----------------------------------------------------------------
  // APB slave decode
  // -----------------------------------------------------------------
  // Setup is the first cycle of a transfer, access the completing edge.
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_reg;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;

  // Address decode of every register this block holds.
  always_comb begin
    mapped = 1'b1;
    case (paddr)
      `IVG_ADDR_PENDING: rdata_next = pending_reg;
      `IVG_ADDR_CONTROL: rdata_next = {30'h00000000, control_reg};
      `IVG_ADDR_COND_STATUS: rdata_next = {22'h000000, cond_status};
      `IVG_ADDR_COND_MASK: rdata_next = {22'h000000, mask_reg};
      `IVG_ADDR_COND_FLAGS: rdata_next = {22'h000000, cond_flags};
      `IVG_ADDR_DATA_REQ: rdata_next = {31'h00000000, data_req_reg};
      `IVG_ADDR_DATA: rdata_next = {24'h000000, parport_rx_byte};
      `IVG_ADDR_VEC_BASE: rdata_next = vec_base_reg;
      default: begin
        rdata_next = `IVG_RST_ZERO;
        mapped = 1'b0;
      end
    endcase
  end

  // Answer with no wait state: ready is raised for the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= `IVG_RST_ZERO;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~mapped;
      if (setup) begin
        prdata_reg <= pwrite ? `IVG_RST_ZERO : rdata_next;
      end
    end
  end

  // An access to an address outside the map raises a trap pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_trap_reg <= 1'b0;
    end else begin
      periph_trap_reg <= access & pslverr_reg;
    end
  end

  // -----------------------------------------------------------------
  // Software registers
  // -----------------------------------------------------------------
  // Control selects channel transfer and the active direction.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= 2'h0;
    end else if (wr && paddr == `IVG_ADDR_CONTROL) begin
      control_reg <= pwdata[1:0];
    end
  end

  // Mask gating each parallel condition onto its flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= `IVG_RST_MASK;
    end else if (wr && paddr == `IVG_ADDR_COND_MASK) begin
      mask_reg <= pwdata[9:0];
    end
  end

  // Vector area base from which table entry addresses are formed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_base_reg <= `IVG_RST_ZERO;
    end else if (wr && paddr == `IVG_ADDR_VEC_BASE) begin
      vec_base_reg <= pwdata;
    end
  end

  // -----------------------------------------------------------------
  // Parallel data transfer request
  // -----------------------------------------------------------------
  // Only the access matching the direction counts as servicing.
  always_comb begin
    data_access = 1'b0;
    if (paddr == `IVG_ADDR_DATA) begin
      if (control_reg[`IVG_CTL_DIR_RX]) begin
        data_access = rd;
      end else begin
        data_access = wr;
      end
    end
  end

  // Write-one clears from the status register or the pending bit.
  assign data_req_clear = data_access
    | (wr && paddr == `IVG_ADDR_DATA_REQ && pwdata[0])
    | (wr && paddr == `IVG_ADDR_PENDING && pwdata[`IVG_BIT_PDATA]);

  // A new byte event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_req_reg <= 1'b0;
    end else if (parport_byte_event) begin
      data_req_reg <= 1'b1;
    end else if (data_req_clear) begin
      data_req_reg <= 1'b0;
    end
  end

  // Byte handoff toward the port and the channel request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_byte_reg <= 8'h00;
      tx_load_reg <= 1'b0;
      rx_taken_reg <= 1'b0;
      dma_req_reg <= 1'b0;
    end else begin
      tx_load_reg <= wr && paddr == `IVG_ADDR_DATA;
      rx_taken_reg <= rd && paddr == `IVG_ADDR_DATA;
      if (wr && paddr == `IVG_ADDR_DATA) begin
        tx_byte_reg <= pwdata[7:0];
      end
      dma_req_reg <= data_req_reg & control_reg[`IVG_CTL_DMA];
    end
  end

  // -----------------------------------------------------------------
  // Parallel control conditions
  // -----------------------------------------------------------------
  // Ones written to status or flag registers clear those conditions; condition 1 clears only on entry to compatibility mode.
  always_comb begin
    cond_clear = 10'h000;
    if (wr && (paddr == `IVG_ADDR_COND_STATUS || paddr == `IVG_ADDR_COND_FLAGS)) begin
      cond_clear = pwdata[9:0];
    end
  end

  ivg_cond_latch u_cond (
    .pclk(pclk),
    .presetn(presetn),
    .cond_event(parport_cond_event),
    .cond_mask(mask_reg),
    .clear_ones(cond_clear),
    .compat_mode(parport_compat_mode),
    .cond_status(cond_status),
    .cond_flags(cond_flags),
    .cond_any(cond_any)
  );

  // Combined bit is sticky and cleared only by its own write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_irq_reg <= 1'b0;
    end else if (cond_any) begin
      cond_irq_reg <= 1'b1;
    end else if (wr && paddr == `IVG_ADDR_PENDING && pwdata[`IVG_BIT_PCOND]) begin
      cond_irq_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Pending status
  // -----------------------------------------------------------------
  // Each bit follows its source level, the data bit only while channel transfer is off; reserved bits stay zero.
  always_comb begin
    pending_next = `IVG_RST_ZERO;
    pending_next[`IVG_BIT_VIDEO] = video_irq;
    pending_next[`IVG_BIT_PIO_HI:`IVG_BIT_PIO_LO] = prog_io_irq_field;
    pending_next[`IVG_BIT_CH0] = channel0_transfer_irq;
    pending_next[`IVG_BIT_CH1] = channel1_transfer_irq;
    pending_next[`IVG_BIT_PDATA] = data_req_reg & ~control_reg[`IVG_CTL_DMA];
    pending_next[`IVG_BIT_PCOND] = cond_irq_reg;
    pending_next[`IVG_BIT_RXS] = serial_rx_status_irq;
    pending_next[`IVG_BIT_RXD] = serial_rx_data_irq;
    pending_next[`IVG_BIT_TXE] = serial_tx_empty_irq;
  end

  // Pending register and the internal peripheral request line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= `IVG_RST_ZERO;
      internal_irq_reg <= 1'b0;
    end else begin
      pending_reg <= pending_next;
      internal_irq_reg <= |pending_next;
    end
  end

  // -----------------------------------------------------------------
  // Vector generation
  // -----------------------------------------------------------------
  // An unsupported address trap takes over the cause in its cycle.
  always_comb begin
    take_next = trap_take | periph_trap_reg;
    cause_next = periph_trap_reg ? ivg_pkg::CAUSE_PERIPH : trap_cause;
  end

  ivg_vector u_vec (
    .pclk(pclk),
    .presetn(presetn),
    .take(take_next),
    .cause(cause_next),
    .miss_kind(trap_miss_kind),
    .emu_opcode(trap_emu_opcode),
    .emu_instr(trap_emu_instr),
    .instr_vector(trap_instr_vector),
    .align_check_enable(align_check_enable),
    .base(vec_base_reg),
    .vec_valid_reg(vec_valid_reg),
    .vec_num_reg(vec_num_reg),
    .vec_addr_reg(vec_addr_reg)
  );

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // Parallel port handoff.
  assign parport_tx_byte = tx_byte_reg;
  assign parport_tx_load = tx_load_reg;
  assign parport_rx_taken = rx_taken_reg;
  assign parport_dma_req = dma_req_reg;
  assign internal_irq = internal_irq_reg;

  // Trap and vector results.
  assign periph_trap = periph_trap_reg;
  assign vector_valid = vec_valid_reg;
  assign vector_num = vec_num_reg;
  assign vector_addr = vec_addr_reg;
endmodule

/* File: design/ivg_vector.sv */
`timescale 1ns/1ps
`include "ivg_consts.svh"
module ivg_vector (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic take,
  input wire ivg_pkg::ivg_cause_t cause,
  input wire logic [1:0] miss_kind,
  input wire logic [7:0] emu_opcode,
  input wire logic [4:0] emu_instr,
  input wire logic [7:0] instr_vector,
  input wire logic align_check_enable,
  input wire logic [31:0] base,
  output logic vec_valid_reg,
  output logic [7:0] vec_num_reg,
  output logic [31:0] vec_addr_reg
);
  logic [7:0] vec_next;
  logic ok_next;
  // -----------------------------------------------------------------
  // Vector number selection
  // -----------------------------------------------------------------
  always_comb begin
    vec_next = `IVG_VEC_ILLEGAL;
    ok_next = 1'b1;
    case (cause)
      ivg_pkg::CAUSE_ILLEGAL: vec_next = `IVG_VEC_ILLEGAL;
      ivg_pkg::CAUSE_UNALIGNED: begin
        vec_next = `IVG_VEC_UNALIGNED;
        ok_next = align_check_enable;
      end
      ivg_pkg::CAUSE_RANGE: vec_next = `IVG_VEC_RANGE;
      ivg_pkg::CAUSE_PROTECT: vec_next = `IVG_VEC_PROTECT;
      ivg_pkg::CAUSE_PERIPH: vec_next = `IVG_VEC_PERIPH;
      ivg_pkg::CAUSE_MISS: vec_next = `IVG_VEC_MISS_BASE + {6'h00, miss_kind};
      ivg_pkg::CAUSE_TIMER: vec_next = `IVG_VEC_TIMER;
      ivg_pkg::CAUSE_TRACE: vec_next = `IVG_VEC_TRACE;
      ivg_pkg::CAUSE_EXT0: vec_next = `IVG_VEC_EXT0;
      ivg_pkg::CAUSE_EXT2: vec_next = `IVG_VEC_EXT2;
      ivg_pkg::CAUSE_INTERNAL: vec_next = `IVG_VEC_INTERNAL;
      ivg_pkg::CAUSE_FPEXC: vec_next = `IVG_VEC_FPEXC;
      ivg_pkg::CAUSE_EMU_OPCODE: begin
        if (emu_opcode >= `IVG_OP_D8 && emu_opcode <= `IVG_OP_DD) begin
          vec_next = emu_opcode - `IVG_OP_D8 + `IVG_VEC_EMU_D8;
        end else if (emu_opcode >= `IVG_OP_E7 && emu_opcode <= `IVG_OP_E9) begin
          vec_next = emu_opcode - `IVG_OP_E7 + `IVG_VEC_EMU_E7;
        end else begin
          ok_next = 1'b0;
        end
      end
      ivg_pkg::CAUSE_EMU_INSTR: vec_next = `IVG_VEC_EMU_INSTR + {3'h0, emu_instr};
      ivg_pkg::CAUSE_INSTR_VEC: vec_next = instr_vector;
      default: ok_next = 1'b0;
    endcase
  end
  // Register the number and merge it into the vector area base.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_valid_reg <= 1'b0;
      vec_num_reg <= 8'h00;
      vec_addr_reg <= `IVG_RST_ZERO;
    end else begin
      vec_valid_reg <= take & ok_next;
      if (take & ok_next) begin
        vec_num_reg <= vec_next;
        vec_addr_reg <= {base[31:10], vec_next, base[1:0]};
      end
    end
  end
endmodule
